// ==== cebs_event_bank.sv ====
`timescale 1ns/10ps
// Function
// - pgood event on output reaching threshold
// - short event when output drops while operating
// - short event if not up within 1 ms
// - curlimit event while limiting was active
// - write one clears, zero leaves bit
// - live thermal shutdown at bit 3
// - live thermal warning at bit 2
// - live enable status at bits 7/3
// - live pgood reads one when below
// - live curlimit at bits 4/0
// - live bits follow inputs, unlatched
// - channel summary clears when events all cleared
// - mask one blocks interrupt, status untouched
module cebs_event_bank
    import cebs_pkg::*;
#(
    parameter int SC_TIMEOUT_CYC = CEBS_SC_TIMEOUT_CYC
) (
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // register port
    input  wire cebs_req_s           req_i,
    output logic                     rvalid_o,
    output logic [7:0]               rdata_o,
    // converter and die conditions
    input  wire cebs_live_s          live_i,
    // interrupt blocking per channel
    input  wire logic [CEBS_NCH-1:0] pgood_irq_block_i,
    input  wire logic [CEBS_NCH-1:0] curlimit_irq_block_i,
    // summary and interrupt
    output logic [CEBS_NCH-1:0]      summary_pending_o,
    output logic                     irq_o
);

    logic [CEBS_NCH-1:0] pgood_prev_reg;
    logic [CEBS_NCH-1:0] pgood_evt;
    logic [CEBS_NCH-1:0] short_evt;
    logic [3:0]          nib_set  [CEBS_NCH];
    logic [7:0]          ev_set   [2];
    logic [7:0]          ev_clr   [2];
    logic [7:0]          ev_q     [2];
    logic [3:0]          ev_nib   [CEBS_NCH];
    logic [3:0]          live_nib [CEBS_NCH];
    logic [3:0]          blk_nib  [CEBS_NCH];
    logic [7:0]          rd_byte;
    logic [7:0]          rdata_reg;
    logic                rvalid_reg;
    logic [CEBS_NCH-1:0] summary_reg;
    logic                irq_reg;
    logic                irq_next;

    // edge of output crossing the power-good threshold
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pgood_prev_reg <= '0;
        end else begin
            pgood_prev_reg <= live_i.above_pgood;
        end
    end

    assign pgood_evt = live_i.above_pgood & ~pgood_prev_reg;

    for (genvar c = 0; c < CEBS_NCH; c++) begin : g_ch
        cebs_short_detect #(
            .TIMEOUT_CYC (SC_TIMEOUT_CYC)
        ) u_short (
            .clk_i       (clk_i),
            .rst_i       (rst_i),
            .enabled_i   (live_i.enabled[c]),
            .above_i     (live_i.above_short[c]),
            .short_evt_o (short_evt[c])
        );

        always_comb begin
            nib_set[c]             = '0;
            nib_set[c][CEBS_EV_PG] = pgood_evt[c];
            nib_set[c][CEBS_EV_SC] = short_evt[c];
            nib_set[c][CEBS_EV_IL] = live_i.curlimit[c];
        end

        // live bits straight from the conditions, no latching
        always_comb begin
            live_nib[c]             = '0;
            live_nib[c][CEBS_ST_EN] = live_i.enabled[c];
            live_nib[c][CEBS_ST_PG] = ~live_i.above_pgood[c];
            live_nib[c][CEBS_ST_IL] = live_i.curlimit[c];
        end

        // short faults have no blocking bit of their own
        always_comb begin
            blk_nib[c]             = '0;
            blk_nib[c][CEBS_EV_PG] = pgood_irq_block_i[c];
            blk_nib[c][CEBS_EV_IL] = curlimit_irq_block_i[c];
        end

        assign ev_nib[c] = (c % 2 == 1) ? ev_q[c / 2][CEBS_HI_OFS +: 4] : ev_q[c / 2][3:0];
    end

    for (genvar p = 0; p < 2; p++) begin : g_pair
        localparam logic [7:0] ADDR = (p == 0) ? CEBS_ADDR_EV01 : CEBS_ADDR_EV23;

        assign ev_set[p] = cebs_pair(nib_set[2 * p], nib_set[2 * p + 1]);
        assign ev_clr[p] = (req_i.wr && req_i.addr == ADDR) ? req_i.wdata : 8'h00;

        cebs_w1c_reg #(
            .WIDTH (8),
            .RSVD  (CEBS_EV_RSVD)
        ) u_flags (
            .clk_i (clk_i),
            .rst_i (rst_i),
            .set_i (ev_set[p]),
            .clr_i (ev_clr[p]),
            .q_o   (ev_q[p])
        );
    end

    // read decode; unmapped offsets read zero
    always_comb begin
        rd_byte = CEBS_RESET_BYTE;
        unique case (req_i.addr)
            CEBS_ADDR_EV01:   rd_byte = ev_q[0];
            CEBS_ADDR_EV23:   rd_byte = ev_q[1];
            CEBS_ADDR_THERM: begin
                rd_byte[CEBS_TH_SD]   = live_i.thermal_sd;
                rd_byte[CEBS_TH_WARN] = live_i.thermal_warn;
            end
            CEBS_ADDR_LIVE01: rd_byte = cebs_pair(live_nib[0], live_nib[1]);
            CEBS_ADDR_LIVE23: rd_byte = cebs_pair(live_nib[2], live_nib[3]);
            default:          rd_byte = CEBS_RESET_BYTE;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_reg  <= CEBS_RESET_BYTE;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= req_i.rd;
            if (req_i.rd) begin
                rdata_reg <= rd_byte;
            end
        end
    end

    // summary reflects the flags as stored, so it drops the cycle after the last clear
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            summary_reg <= '0;
        end else begin
            for (int c = 0; c < CEBS_NCH; c++) begin
                summary_reg[c] <= |ev_nib[c];
            end
        end
    end

    always_comb begin
        irq_next = 1'b0;
        for (int c = 0; c < CEBS_NCH; c++) begin
            irq_next = irq_next | (|(ev_nib[c] & ~blk_nib[c]));
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    assign rdata_o           = rdata_reg;
    assign rvalid_o          = rvalid_reg;
    assign summary_pending_o = summary_reg;
    assign irq_o             = irq_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_pgood_latch: assert property (
        (live_i.above_pgood[0] && !pgood_prev_reg[0]) |=> ev_q[0][CEBS_EV_PG])
        else $error("pgood event not latched");
    a_curlim_latch: assert property (
        live_i.curlimit[3] |=> ev_q[1][CEBS_HI_OFS + CEBS_EV_IL])
        else $error("current limit event not latched");
    a_event_read: assert property (
        (req_i.rd && req_i.addr == CEBS_ADDR_EV01) |=> (rvalid_reg && rdata_reg == $past(ev_q[0])))
        else $error("event read wrong");
    a_thermal_read: assert property (
        (req_i.rd && req_i.addr == CEBS_ADDR_THERM)
        |=> rdata_reg == {4'h0, $past(live_i.thermal_sd), $past(live_i.thermal_warn), 2'h0})
        else $error("thermal status read wrong");
    a_live_read: assert property (
        (req_i.rd && req_i.addr == CEBS_ADDR_LIVE01)
        |=> (rdata_reg[CEBS_HI_OFS + CEBS_ST_PG] == !$past(live_i.above_pgood[1])
             && rdata_reg[CEBS_ST_EN] == $past(live_i.enabled[0])
             && rdata_reg[CEBS_ST_IL] == $past(live_i.curlimit[0])))
        else $error("live status read wrong");
    a_summary_clear: assert property (
        (ev_nib[3] == 4'h0) |=> !summary_reg[3])
        else $error("summary did not clear");
    a_summary_set: assert property (
        (ev_nib[2] != 4'h0) |=> summary_reg[2])
        else $error("summary missing");
    a_irq_blocked: assert property (
        (ev_q[0] == 8'h04 && ev_q[1] == 8'h00 && pgood_irq_block_i[0]) |=> !irq_reg)
        else $error("blocked event raised interrupt");
    a_irq_short: assert property (
        ev_q[0][CEBS_EV_SC] |=> irq_reg)
        else $error("short event raised no interrupt");
    a_unmapped_zero: assert property (
        (req_i.rd && req_i.addr == 8'h00) |=> rdata_reg == CEBS_RESET_BYTE)
        else $error("unmapped read nonzero");

    // every channel latches its own power-good edge
    a_pgood_ch1: assert property (
        (live_i.above_pgood[1] && !pgood_prev_reg[1]) |=> ev_q[0][CEBS_HI_OFS + CEBS_EV_PG])
        else $error("pgood event not latched");
    a_pgood_ch2: assert property (
        (live_i.above_pgood[2] && !pgood_prev_reg[2]) |=> ev_q[1][CEBS_EV_PG])
        else $error("pgood event not latched");
    a_pgood_ch3: assert property (
        (live_i.above_pgood[3] && !pgood_prev_reg[3]) |=> ev_q[1][CEBS_HI_OFS + CEBS_EV_PG])
        else $error("pgood event not latched");

    // current limit sets its flag in every active cycle
    a_curlim_ch0: assert property (
        live_i.curlimit[0] |=> ev_q[0][CEBS_EV_IL])
        else $error("current limit event not latched");
    a_curlim_ch1: assert property (
        live_i.curlimit[1] |=> ev_q[0][CEBS_HI_OFS + CEBS_EV_IL])
        else $error("current limit event not latched");
    a_curlim_ch2: assert property (
        live_i.curlimit[2] |=> ev_q[1][CEBS_EV_IL])
        else $error("current limit event not latched");

    // a detector pulse lands in its own channel's short flag
    a_short_ch0: assert property (
        short_evt[0] |=> ev_q[0][CEBS_EV_SC])
        else $error("short event not latched");
    a_short_ch1: assert property (
        short_evt[1] |=> ev_q[0][CEBS_HI_OFS + CEBS_EV_SC])
        else $error("short event not latched");
    a_short_ch2: assert property (
        short_evt[2] |=> ev_q[1][CEBS_EV_SC])
        else $error("short event not latched");
    a_short_ch3: assert property (
        short_evt[3] |=> ev_q[1][CEBS_HI_OFS + CEBS_EV_SC])
        else $error("short event not latched");

    // summary follows each channel's nibble one cycle later
    a_sumset_ch0: assert property (
        (ev_nib[0] != 4'h0) |=> summary_reg[0])
        else $error("summary missing");
    a_sumset_ch1: assert property (
        (ev_nib[1] != 4'h0) |=> summary_reg[1])
        else $error("summary missing");
    a_sumset_ch3: assert property (
        (ev_nib[3] != 4'h0) |=> summary_reg[3])
        else $error("summary missing");
    a_sumclr_ch0: assert property (
        (ev_nib[0] == 4'h0) |=> !summary_reg[0])
        else $error("summary did not clear");
    a_sumclr_ch1: assert property (
        (ev_nib[1] == 4'h0) |=> !summary_reg[1])
        else $error("summary did not clear");
    a_sumclr_ch2: assert property (
        (ev_nib[2] == 4'h0) |=> !summary_reg[2])
        else $error("summary did not clear");

    // read path for the upper pair
    a_live23_read: assert property (
        (req_i.rd && req_i.addr == CEBS_ADDR_LIVE23)
        |=> (rdata_reg[CEBS_HI_OFS + CEBS_ST_EN] == $past(live_i.enabled[3])
             && rdata_reg[CEBS_ST_PG] == !$past(live_i.above_pgood[2])
             && rdata_reg[CEBS_HI_OFS + CEBS_ST_IL] == $past(live_i.curlimit[3])))
        else $error("live status read wrong");
    a_ev23_read: assert property (
        (req_i.rd && req_i.addr == CEBS_ADDR_EV23) |=> (rvalid_reg && rdata_reg == $past(ev_q[1])))
        else $error("event read wrong");
    a_rsvd_read: assert property (
        (req_i.rd && req_i.addr == CEBS_ADDR_EV23) |=> ((rdata_reg & CEBS_EV_RSVD) == 8'h00))
        else $error("reserved event bit read nonzero");

    // clearing the pgood flag, and blocking on the current limit path
    a_clear_pgood: assert property (
        (req_i.wr && req_i.addr == CEBS_ADDR_EV01 && req_i.wdata[CEBS_EV_PG] && !pgood_evt[0])
        |=> !ev_q[0][CEBS_EV_PG])
        else $error("write one did not clear pgood flag");
    a_irq_curlim: assert property (
        (ev_q[1][CEBS_EV_IL] && !curlimit_irq_block_i[2]) |=> irq_reg)
        else $error("unblocked current limit raised no interrupt");
    a_curlim_blocked: assert property (
        (ev_q[0] == 8'h10 && ev_q[1] == 8'h00 && curlimit_irq_block_i[1]) |=> !irq_reg)
        else $error("blocked current limit raised interrupt");

    c_clear_event: cover property (ev_q[0] != 8'h00 ##1 (req_i.wr && req_i.addr == CEBS_ADDR_EV01));
    c_summary_drop: cover property (summary_reg[0] ##1 !summary_reg[0]);
    c_set_and_clear: cover property (|(ev_set[1] & ev_clr[1]));
    c_irq_rise: cover property (!irq_reg ##1 irq_reg);

endmodule : cebs_event_bank

// ==== cebs_host_model.sv ====
`timescale 1ns/10ps
module cebs_host_model
    import cebs_pkg::*;
(
    // clock
    input  wire logic       clk_i,
    // read answer from the device
    input  wire logic       rvalid_i,
    input  wire logic [7:0] rdata_i,
    // request to the device
    output cebs_req_s       req_o
);
    initial req_o = '0;

    // a one in data clears that flag, a zero leaves it alone
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_i);
        #1;
        req_o = '{1'h1, 1'h0, addr, data};
        @(posedge clk_i);
        #1;
        req_o = '0;
    endtask : wr

    // ok stays high only for a single-cycle valid pulse after the strobe
    task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic ok);
        @(posedge clk_i);
        #1;
        req_o = '{1'h0, 1'h1, addr, 8'h00};
        @(posedge clk_i);
        #1;
        req_o = '0;
        ok    = rvalid_i;
        data  = rdata_i;
        @(posedge clk_i);
        #1;
        ok = ok & ~rvalid_i;
    endtask : rd
endmodule : cebs_host_model

// ==== cebs_pkg.sv ====
package cebs_pkg;

    localparam int CEBS_NCH = 4;

    // register offsets on the serial register port
    localparam logic [7:0] CEBS_ADDR_EV01   = 8'h19;
    localparam logic [7:0] CEBS_ADDR_EV23   = 8'h1A;
    localparam logic [7:0] CEBS_ADDR_THERM  = 8'h1B;
    localparam logic [7:0] CEBS_ADDR_LIVE01 = 8'h1C;
    localparam logic [7:0] CEBS_ADDR_LIVE23 = 8'h1D;

    localparam logic [7:0] CEBS_RESET_BYTE = 8'h00;
    localparam logic [7:0] CEBS_EV_RSVD    = 8'h88;

    // field positions inside one byte; odd channel adds CEBS_HI_OFS
    localparam int CEBS_HI_OFS  = 4;
    localparam int CEBS_EV_PG   = 2;
    localparam int CEBS_EV_SC   = 1;
    localparam int CEBS_EV_IL   = 0;
    localparam int CEBS_ST_EN   = 3;
    localparam int CEBS_ST_PG   = 2;
    localparam int CEBS_ST_IL   = 0;
    localparam int CEBS_TH_SD   = 3;
    localparam int CEBS_TH_WARN = 2;

    // start-up short timeout, longest time so rounded down
    localparam int CEBS_CLK_MHZ        = 250;
    localparam int CEBS_SC_TIMEOUT_US  = 1000;
    localparam int CEBS_SC_TIMEOUT_CYC = CEBS_SC_TIMEOUT_US * CEBS_CLK_MHZ;

    typedef struct packed {
        logic [CEBS_NCH-1:0] enabled;
        logic [CEBS_NCH-1:0] above_pgood;
        logic [CEBS_NCH-1:0] above_short;
        logic [CEBS_NCH-1:0] curlimit;
        logic                thermal_sd;
        logic                thermal_warn;
    } cebs_live_s;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cebs_req_s;

    // place the nibbles of an even/odd channel pair into one byte, even channel low
    function automatic logic [7:0] cebs_pair(input logic [3:0] lo, input logic [3:0] hi);
        cebs_pair = {hi, lo};
    endfunction : cebs_pair

endpackage : cebs_pkg

// ==== cebs_short_detect.sv ====
`timescale 1ns/10ps
module cebs_short_detect
    import cebs_pkg::*;
#(
    parameter int TIMEOUT_CYC = CEBS_SC_TIMEOUT_CYC
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // channel state
    input  wire logic enabled_i,
    input  wire logic above_i,
    // one-cycle short event
    output logic      short_evt_o
);

    localparam int CW = $clog2(TIMEOUT_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(TIMEOUT_CYC - 1);

    typedef enum logic [3:0] {
        SD_IDLE = 4'h1,
        SD_RAMP = 4'h2,
        SD_RUN  = 4'h4,
        SD_HOLD = 4'h8
    } cebs_sd_e;

    cebs_sd_e      state_reg;
    logic [CW-1:0] cnt_reg;
    logic          evt_reg;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= SD_IDLE;
            evt_reg   <= 1'b0;
        end else begin
            evt_reg <= 1'b0;
            unique case (state_reg)
                SD_IDLE: begin
                    if (enabled_i) begin
                        state_reg <= SD_RAMP;
                    end
                end
                SD_RAMP: begin
                    if (!enabled_i) begin
                        state_reg <= SD_IDLE;
                    end else if (above_i) begin
                        state_reg <= SD_RUN;
                    end else if (cnt_reg == LAST) begin
                        evt_reg   <= 1'b1;
                        state_reg <= SD_HOLD;
                    end
                end
                SD_RUN: begin
                    if (!enabled_i) begin
                        state_reg <= SD_IDLE;
                    end else if (!above_i) begin
                        evt_reg   <= 1'b1;
                        state_reg <= SD_HOLD;
                    end
                end
                SD_HOLD: begin
                    // one event per fault; rearm once the output recovers
                    if (!enabled_i) begin
                        state_reg <= SD_IDLE;
                    end else if (above_i) begin
                        state_reg <= SD_RUN;
                    end
                end
                default: state_reg <= SD_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg <= '0;
        end else if (state_reg == SD_RAMP) begin
            cnt_reg <= cnt_reg + CW'(1);
        end else begin
            cnt_reg <= '0;
        end
    end

    assign short_evt_o = evt_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_timeout_fires: assert property (
        (state_reg == SD_RAMP && enabled_i && !above_i && cnt_reg == LAST) |=> evt_reg)
        else $error("start-up timeout missed");
    a_no_early_fire: assert property (
        (state_reg == SD_RAMP && cnt_reg != LAST) |=> !evt_reg)
        else $error("short event before timeout");
    a_run_drop: assert property (
        (state_reg == SD_RUN && enabled_i && !above_i) |=> evt_reg ##1 !evt_reg)
        else $error("drop below short level missed");
    c_timeout: cover property (state_reg == SD_RAMP ##1 state_reg == SD_HOLD);

endmodule : cebs_short_detect

// ==== cebs_w1c_reg.sv ====
`timescale 1ns/10ps
module cebs_w1c_reg
    import cebs_pkg::*;
#(
    parameter int         WIDTH = 8,
    parameter logic [7:0] RSVD  = CEBS_EV_RSVD
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // hardware set, software clear
    input  wire logic [WIDTH-1:0] set_i,
    input  wire logic [WIDTH-1:0] clr_i,
    // stored flags
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] q_reg;
    logic [WIDTH-1:0] q_next;
    logic [WIDTH-1:0] keep;

    assign keep   = ~RSVD[WIDTH-1:0];
    // set after clear so an event in the clearing cycle survives
    assign q_next = ((q_reg & ~clr_i) | set_i) & keep;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q_reg <= CEBS_RESET_BYTE[WIDTH-1:0];
        end else begin
            q_reg <= q_next;
        end
    end

    assign q_o = q_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_set_wins_clear: assert property (
        (|(set_i & keep)) |=> ((q_reg & $past(set_i & keep)) == $past(set_i & keep)))
        else $error("set flag lost");
    a_clear_on_one: assert property (
        (|(clr_i & ~set_i)) |=> ((q_reg & $past(clr_i & ~set_i)) == '0))
        else $error("write one did not clear");
    a_zero_keeps: assert property (
        ((clr_i | set_i) == '0) |=> (q_reg == $past(q_reg)))
        else $error("flag changed without cause");
    a_rsvd_zero: assert property ((q_reg & RSVD[WIDTH-1:0]) == '0)
        else $error("reserved bit set");

endmodule : cebs_w1c_reg

// ==== tb_top.sv ====
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; $display("[ERR] t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb_top;
    import cebs_pkg::*;
    // short start-up timeout keeps the run brief
    localparam int SC_CYC = 20;

    logic                clk_i = 1'h0;
    logic                rst_i = 1'h1;
    cebs_req_s           req_i;
    logic                rvalid_o;
    logic [7:0]          rdata_o;
    cebs_live_s          live_i;
    logic [CEBS_NCH-1:0] pg_blk;
    logic [CEBS_NCH-1:0] il_blk;
    logic [CEBS_NCH-1:0] summary_pending_o;
    logic                irq_o;
    int                  failures = 0;
    int                  num_checks = 0;

    always #2 clk_i = ~clk_i;

    cebs_event_bank #(.SC_TIMEOUT_CYC(SC_CYC)) dut_u (
        .clk_i                (clk_i),
        .rst_i                (rst_i),
        .req_i                (req_i),
        .rvalid_o             (rvalid_o),
        .rdata_o              (rdata_o),
        .live_i               (live_i),
        .pgood_irq_block_i    (pg_blk),
        .curlimit_irq_block_i (il_blk),
        .summary_pending_o    (summary_pending_o),
        .irq_o                (irq_o)
    );

    cebs_host_model host_u (
        .clk_i    (clk_i),
        .rvalid_i (rvalid_o),
        .rdata_i  (rdata_o),
        .req_o    (req_i)
    );

    task automatic wrap_up();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : idle

    task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        host_u.rd(addr, d, ok);
        `CHK(ok, 1'h1)
        `CHK(d, exp)
    endtask : rchk

    task automatic t_reset();
        logic [7:0] a [6] = '{CEBS_ADDR_EV01, CEBS_ADDR_EV23, CEBS_ADDR_THERM,
                              CEBS_ADDR_LIVE01, CEBS_ADDR_LIVE23, 8'h00};
        // live power-good bits read one while the outputs are still down
        logic [7:0] e [6] = '{8'h00, 8'h00, 8'h00, 8'h44, 8'h44, 8'h00};
        `CHK(summary_pending_o, 4'h0)
        `CHK(irq_o, 1'h0)
        foreach (a[i]) rchk(a[i], e[i]);
    endtask : t_reset

    task automatic t_live();
        live_i.enabled     = 4'h5;
        live_i.above_pgood = 4'h3;
        live_i.curlimit    = 4'h8;
        live_i.thermal_sd  = 1'h1;
        idle(2);
        rchk(CEBS_ADDR_THERM, 8'h08);
        rchk(CEBS_ADDR_LIVE01, 8'h08);
        rchk(CEBS_ADDR_LIVE23, 8'h5C);
        live_i.thermal_sd   = 1'h0;
        live_i.thermal_warn = 1'h1;
        live_i.curlimit     = 4'h0;
        live_i.above_pgood  = 4'h7;
        idle(2);
        rchk(CEBS_ADDR_THERM, 8'h04);
        rchk(CEBS_ADDR_LIVE23, 8'h48);
        rchk(CEBS_ADDR_EV23, 8'h14);
        rchk(CEBS_ADDR_EV01, 8'h44);
        host_u.wr(CEBS_ADDR_EV01, 8'hFF);
        host_u.wr(CEBS_ADDR_EV23, 8'hFF);
        rchk(CEBS_ADDR_EV01, 8'h00);
        rchk(CEBS_ADDR_EV23, 8'h00);
    endtask : t_live

    task automatic t_events();
        live_i.above_pgood[1] = 1'h0;
        idle(2);
        live_i.above_pgood[1] = 1'h1;
        live_i.curlimit[2]    = 1'h1;
        idle(1);
        live_i.curlimit[2] = 1'h0;
        idle(2);
        rchk(CEBS_ADDR_EV01, 8'h40);
        rchk(CEBS_ADDR_EV23, 8'h01);
        `CHK(summary_pending_o, 4'h6)
        host_u.wr(CEBS_ADDR_EV01, 8'h00);
        host_u.wr(CEBS_ADDR_EV01, 8'hBF);
        rchk(CEBS_ADDR_EV01, 8'h40);
        host_u.wr(CEBS_ADDR_EV01, 8'h40);
        host_u.wr(CEBS_ADDR_EV23, 8'h01);
        idle(2);
        `CHK(summary_pending_o, 4'h0)
        rchk(CEBS_ADDR_EV01, 8'h00);
        host_u.wr(CEBS_ADDR_THERM, 8'hFF);
        rchk(CEBS_ADDR_THERM, 8'h04);
    endtask : t_events

    task automatic t_short();
        live_i.above_short[0] = 1'h0;
        idle(3);
        rchk(CEBS_ADDR_EV01, 8'h02);
        live_i.above_short[0] = 1'h1;
        // channel 3 enabled but its output never comes up
        live_i.above_short[3] = 1'h0;
        live_i.enabled[3]     = 1'h1;
        // last read before the timeout flag lands, then the first read after it
        idle(SC_CYC - 1);
        rchk(CEBS_ADDR_EV23, 8'h00);
        rchk(CEBS_ADDR_EV23, 8'h20);
        live_i.enabled[3]     = 1'h0;
        live_i.above_short[3] = 1'h1;
        host_u.wr(CEBS_ADDR_EV01, 8'hFF);
        host_u.wr(CEBS_ADDR_EV23, 8'hFF);
    endtask : t_short

    task automatic t_mask();
        pg_blk                = 4'h1;
        live_i.above_pgood[0] = 1'h0;
        idle(2);
        live_i.above_pgood[0] = 1'h1;
        idle(3);
        `CHK(irq_o, 1'h0)
        `CHK(summary_pending_o, 4'h1)
        rchk(CEBS_ADDR_LIVE01, 8'h08);
        pg_blk = 4'h0;
        il_blk = 4'h2;
        idle(2);
        `CHK(irq_o, 1'h1)
        live_i.curlimit[1] = 1'h1;
        idle(1);
        live_i.curlimit[1] = 1'h0;
        host_u.wr(CEBS_ADDR_EV01, 8'h04);
        idle(2);
        `CHK(irq_o, 1'h0)
        il_blk = 4'h0;
        idle(2);
        `CHK(irq_o, 1'h1)
        host_u.wr(CEBS_ADDR_EV01, 8'hFF);
        idle(2);
        `CHK(irq_o, 1'h0)
        `CHK(summary_pending_o, 4'h0)
    endtask : t_mask

    initial begin
        live_i             = '0;
        live_i.above_short = 4'hF;
        pg_blk             = 4'h0;
        il_blk             = 4'h0;
        repeat (6) @(posedge clk_i);
        #1;
        rst_i = 1'h0;
        t_reset();
        t_live();
        t_events();
        t_short();
        t_mask();
        wrap_up();
    end

    // the tests need well under a thousand cycles
    initial begin
        #40000;
        failures++;
        wrap_up();
    end
endmodule : tb_top
